// [rtl/lics_regs.sv]
// Line-interface control and status register bank on the control port.
`default_nettype none
module lics_regs (
   input wire logic clk,
   input wire logic reset,
   input wire lics_pkg::lics_bus_t bus,
   input wire lics_pkg::lics_line_t line,
   output logic [7:0] rdata,
   output logic rvalid,
   output logic irq,
   output logic line_code_inversion_enable,
   output logic line_code_invert,
   output logic external_resistor_select,
   output lics_pkg::lics_term_t rx_term,
   output lics_pkg::lics_term_t tx_term,
   output logic [1:0] master_clock_prescale,
   input wire logic jitter_clock_select_0,
   input wire logic jitter_clock_select_1,
   output logic pll_t1_enable,
   output logic pll_e1_enable
);
   lics_pkg::lics_state_t s_r, s_nxt;
   logic open_q, clim_q;

   ////////////////////////////////////////////////////////////////////
   // Receive keeps the external resistor when no internal value is chosen,
   // while transmit simply switches its termination off.
   function automatic lics_pkg::lics_term_t dec(input logic [2:0] c,
                                                input logic rx);
      case (c)
         3'h1: dec = lics_pkg::LICS_TERM_75;
         3'h2: dec = lics_pkg::LICS_TERM_100;
         3'h3: dec = lics_pkg::LICS_TERM_120;
         3'h4: dec = lics_pkg::LICS_TERM_110;
         3'h5: dec = lics_pkg::LICS_TERM_133;
         default: dec = rx ? lics_pkg::LICS_TERM_EXT
                           : lics_pkg::LICS_TERM_OFF;
      endcase
   endfunction

   always_comb begin
      open_q = line.tx_open_circuit & ~line.mode_6312k;
      clim_q = line.tx_current_limit & ~line.mode_6312k & ~line.mode_64k
               & ~s_r.code_ctl[lics_pkg::LICS_BIT_CMIEN];
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.rvalid = 1'b0;
      s_nxt.level = line.rx_level;
      s_nxt.status[lics_pkg::LICS_BIT_OPEN] = open_q;
      s_nxt.status[lics_pkg::LICS_BIT_CLIM] = clim_q;
      s_nxt.jlim_prev = line.jitter_near_limit;
      s_nxt.pll_t1 = jitter_clock_select_0;
      s_nxt.pll_e1 = jitter_clock_select_1;
      if (bus.wr) begin
         case (bus.addr)
            lics_pkg::LICS_ADDR_MASK:
               s_nxt.mask = bus.wdata & lics_pkg::LICS_FLAG_MASK;
            lics_pkg::LICS_ADDR_CODE: s_nxt.code_ctl = bus.wdata;
            lics_pkg::LICS_ADDR_TERM: s_nxt.term_ctl = bus.wdata;
            default: ;
         endcase
      end
      if (bus.rd) begin
         s_nxt.rvalid = 1'b1;
         case (bus.addr)
            lics_pkg::LICS_ADDR_INFO: s_nxt.rdata = {4'h0, s_r.level};
            lics_pkg::LICS_ADDR_STATUS: s_nxt.rdata = s_r.status;
            lics_pkg::LICS_ADDR_MASK: s_nxt.rdata = s_r.mask;
            lics_pkg::LICS_ADDR_CODE: s_nxt.rdata = s_r.code_ctl;
            lics_pkg::LICS_ADDR_TERM: s_nxt.rdata = s_r.term_ctl;
            default: s_nxt.rdata = 8'h00;
         endcase
      end
      // read clears event; read services interrupt
      if (bus.rd && bus.addr == lics_pkg::LICS_ADDR_STATUS) begin
         s_nxt.status[lics_pkg::LICS_BIT_JALIM] = 1'b0;
         s_nxt.irq = 1'b0;
      end
      // rising edge sets event, set wins over read clear
      if (line.jitter_near_limit && !s_r.jlim_prev)
         s_nxt.status[lics_pkg::LICS_BIT_JALIM] = 1'b1;
      // both edges, event gate, sticky request
      if ((s_r.mask[lics_pkg::LICS_BIT_OPEN] &&
           (open_q != s_r.status[lics_pkg::LICS_BIT_OPEN])) ||
          (s_r.mask[lics_pkg::LICS_BIT_CLIM] &&
           (clim_q != s_r.status[lics_pkg::LICS_BIT_CLIM])) ||
          (s_r.mask[lics_pkg::LICS_BIT_JALIM] &&
           line.jitter_near_limit && !s_r.jlim_prev))
         s_nxt.irq = 1'b1;
      s_nxt.rx_term = dec(s_nxt.term_ctl[lics_pkg::LICS_RXT_LSB +: 3], 1'b1);
      s_nxt.tx_term = dec(s_nxt.term_ctl[lics_pkg::LICS_TXT_LSB +: 3], 1'b0);
      if (reset) begin
         s_nxt = '0;
         s_nxt.code_ctl = lics_pkg::LICS_RESET_VAL;
         s_nxt.term_ctl = lics_pkg::LICS_RESET_VAL;
         s_nxt.mask = lics_pkg::LICS_RESET_VAL;
         // The all-zero codes decode to the external resistor and to off.
         s_nxt.rx_term = lics_pkg::LICS_TERM_EXT;
         s_nxt.tx_term = lics_pkg::LICS_TERM_OFF;
      end
   end

   always_ff @(posedge clk) begin
      s_r <= s_nxt;
   end

   ////////////////////////////////////////////////////////////////////
   // The PLL selects are captured, so enables lag the pins by one clock.
   assign rdata = s_r.rdata;
   assign rvalid = s_r.rvalid;
   assign irq = s_r.irq;
   assign line_code_inversion_enable = s_r.code_ctl[lics_pkg::LICS_BIT_CMIEN];
   assign line_code_invert = s_r.code_ctl[lics_pkg::LICS_BIT_INV];
   assign external_resistor_select = s_r.code_ctl[lics_pkg::LICS_BIT_EXTRES];
   assign rx_term = s_r.rx_term;
   assign tx_term = s_r.tx_term;
   assign master_clock_prescale = s_r.term_ctl[lics_pkg::LICS_MPS_LSB +: 2];
   assign pll_t1_enable = s_r.pll_t1;
   assign pll_e1_enable = s_r.pll_e1;

   ////////////////////////////////////////////////////////////////////
   // Flags and outputs are registered, so each check except the termination decode checks looks one clock on.
   property p_jal_set;
      @(posedge clk) disable iff (reset)
      line.jitter_near_limit && !s_r.jlim_prev |=>
      s_r.status[lics_pkg::LICS_BIT_JALIM];
   endproperty
   a_jal_set: assert property (p_jal_set) else $error("event lost");

   // A new event in the read cycle wins, so it is left out here.
   property p_rdclr;
      @(posedge clk) disable iff (reset)
      bus.rd && bus.addr == lics_pkg::LICS_ADDR_STATUS &&
      !(line.jitter_near_limit && !s_r.jlim_prev) &&
      open_q == s_r.status[lics_pkg::LICS_BIT_OPEN] &&
      clim_q == s_r.status[lics_pkg::LICS_BIT_CLIM]
      |=> !s_r.status[lics_pkg::LICS_BIT_JALIM] && !irq;
   endproperty
   a_rdclr: assert property (p_rdclr) else $error("no read clear");

   property p_edge;
      @(posedge clk) disable iff (reset)
      s_r.mask[lics_pkg::LICS_BIT_OPEN] && $changed(open_q) |=> irq;
   endproperty
   a_edge: assert property (p_edge) else $error("no edge irq");

   property p_clim_edge;
      @(posedge clk) disable iff (reset)
      s_r.mask[lics_pkg::LICS_BIT_CLIM] && $changed(clim_q) |=> irq;
   endproperty
   a_clim_edge: assert property (p_clim_edge) else $error("no limit irq");

   property p_masked;
      @(posedge clk) disable iff (reset)
      s_r.mask == 8'h00 && !irq |=> !irq;
   endproperty
   a_masked: assert property (p_masked) else $error("masked irq");

   property p_hold;
      @(posedge clk) disable iff (reset)
      irq && !(bus.rd && bus.addr == lics_pkg::LICS_ADDR_STATUS) |=> irq;
   endproperty
   a_hold: assert property (p_hold) else $error("irq dropped");

   property p_lvl;
      @(posedge clk) disable iff (reset)
      1'b1 |=> s_r.level == $past(line.rx_level);
   endproperty
   a_lvl: assert property (p_lvl) else $error("level stale");

   property p_inv;
      @(posedge clk) disable iff (reset)
      bus.wr && bus.addr == lics_pkg::LICS_ADDR_CODE |=>
      line_code_invert == $past(bus.wdata[lics_pkg::LICS_BIT_INV]) &&
      line_code_inversion_enable == $past(bus.wdata[lics_pkg::LICS_BIT_CMIEN]);
   endproperty
   a_inv: assert property (p_inv) else $error("code ctl wrong");

   property p_clim;
      @(posedge clk) disable iff (reset)
      line.mode_64k |=> !s_r.status[lics_pkg::LICS_BIT_CLIM];
   endproperty
   a_clim: assert property (p_clim) else $error("limit in 64k");

   property p_open;
      @(posedge clk) disable iff (reset)
      line.mode_6312k |=> !s_r.status[lics_pkg::LICS_BIT_OPEN];
   endproperty
   a_open: assert property (p_open) else $error("open in 6312k");

   property p_pll;
      @(posedge clk) disable iff (reset)
      1'b1 |=> pll_t1_enable == $past(jitter_clock_select_0);
   endproperty
   a_pll: assert property (p_pll) else $error("pll off");

   property p_pll_e1;
      @(posedge clk) disable iff (reset)
      1'b1 |=> pll_e1_enable == $past(jitter_clock_select_1);
   endproperty
   a_pll_e1: assert property (p_pll_e1) else $error("e1 pll wrong");

   property p_rx_ext;
      @(posedge clk) disable iff (reset)
      s_r.term_ctl[lics_pkg::LICS_RXT_LSB +: 3] inside {3'h0, 3'h6, 3'h7}
      |-> rx_term == lics_pkg::LICS_TERM_EXT;
   endproperty
   a_rx_ext: assert property (p_rx_ext) else $error("rx not ext");

   property p_rx_133;
      @(posedge clk) disable iff (reset)
      s_r.term_ctl[lics_pkg::LICS_RXT_LSB +: 3] == 3'h5
      |-> rx_term == lics_pkg::LICS_TERM_133;
   endproperty
   a_rx_133: assert property (p_rx_133) else $error("rx not 133");

   property p_tx_off;
      @(posedge clk) disable iff (reset)
      s_r.term_ctl[lics_pkg::LICS_TXT_LSB +: 3] inside {3'h0, 3'h6, 3'h7}
      |-> tx_term == lics_pkg::LICS_TERM_OFF;
   endproperty
   a_tx_off: assert property (p_tx_off) else $error("tx not off");

   c_irq: cover property (@(posedge clk) $rose(irq));
   c_clr: cover property (@(posedge clk) $fell(irq));
   c_t133: cover property (@(posedge clk) rx_term == lics_pkg::LICS_TERM_133);
   c_jal: cover property (@(posedge clk)
      $rose(s_r.status[lics_pkg::LICS_BIT_JALIM]));
   c_clim: cover property (@(posedge clk)
      $rose(s_r.status[lics_pkg::LICS_BIT_CLIM]));
endmodule
`default_nettype wire

// [rtl/lics_pkg.sv]
// Package for the line-interface control and status register bank.
// Functional notes
// - Line code invert bit six inverts coded-mark-inversion at transmit and receive.
// - Line code control bit seven enables coded-mark-inversion line coding.
// - Receive termination code decodes to 75/100/120/110/133 ohm, else external resistor.
// - Transmit termination code decodes to 75/100/120/110/133 ohm, others disabled.
// - Receive level reported live as four-bit code in 2.5 dB bands.
// - Open-circuit flag follows detector, unsupported in 6312 kHz mode.
// - Current-limit flag follows limiter, unsupported in inversion, 64k, 6312k modes.
// - Jitter FIFO limit event flag set within four bits of limit.
// - Host read of status register clears the jitter limit event flag.
// - Masked-in open-circuit and current-limit flags interrupt on both edges.
// - Mask bit four gates the jitter limit event interrupt.
// - Jitter clock select zero enables 2.048 to 1.544 MHz PLL.
// - Jitter clock select one enables 12.8 to 2.048 MHz PLL.
`default_nettype none
package lics_pkg;
   localparam logic [7:0] LICS_ADDR_INFO = 8'h11;
   localparam logic [7:0] LICS_ADDR_STATUS = 8'h14;
   localparam logic [7:0] LICS_ADDR_MASK = 8'h15;
   localparam logic [7:0] LICS_ADDR_CODE = 8'h32;
   localparam logic [7:0] LICS_ADDR_TERM = 8'h33;
   localparam logic [7:0] LICS_RESET_VAL = 8'h00;
   localparam int LICS_BIT_OPEN = 1;
   localparam int LICS_BIT_CLIM = 2;
   localparam int LICS_BIT_JALIM = 4;
   localparam int LICS_BIT_INV = 6;
   localparam int LICS_BIT_CMIEN = 7;
   localparam int LICS_BIT_EXTRES = 5;
   localparam int LICS_RXT_LSB = 0;
   localparam int LICS_TXT_LSB = 3;
   localparam int LICS_MPS_LSB = 6;
   localparam logic [7:0] LICS_FLAG_MASK = 8'h16;

   typedef enum logic [2:0] {
      LICS_TERM_EXT, LICS_TERM_75, LICS_TERM_100, LICS_TERM_120,
      LICS_TERM_110, LICS_TERM_133, LICS_TERM_OFF
   } lics_term_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } lics_bus_t;

   typedef struct packed {
      logic tx_open_circuit;
      logic tx_current_limit;
      logic jitter_near_limit;
      logic [3:0] rx_level;
      logic mode_6312k;
      logic mode_64k;
   } lics_line_t;

   typedef struct packed {
      logic [7:0] code_ctl;
      logic [7:0] term_ctl;
      logic [7:0] mask;
      logic [7:0] status;
      logic [3:0] level;
      logic jlim_prev;
      logic irq;
      logic pll_t1;
      logic pll_e1;
      logic [7:0] rdata;
      logic rvalid;
      lics_term_t rx_term;
      lics_term_t tx_term;
   } lics_state_t;
endpackage
`default_nettype wire

// [verif/lics_host.sv]
// Host processor model that drives the byte-wide control port.
`default_nettype none
module lics_host (
   input wire logic clk,
   output lics_pkg::lics_bus_t bus,
   input wire logic [7:0] rdata,
   input wire logic rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   initial bus = '0;
   // Released address and data show the inverse so stale values never match.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
      ok = 1'b0;
      d = 8'h00;
      @(posedge clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
      for (int i = 0; i < 4 && !ok; i++) begin
         #1;
         if (rvalid === 1'b1) begin
            ok = 1'b1;
            d = rdata;
         end
         else @(posedge clk);
      end
   endtask
endmodule
`default_nettype wire

// [verif/lics_regs_test.sv]
// Self-checking bench for the line-interface register bank.
`default_nettype none
module lics_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic js0 = 1'b0;
   logic js1 = 1'b0;
   lics_pkg::lics_bus_t bus;
   lics_pkg::lics_line_t ln = '0;
   logic [7:0] rdata;
   logic rvalid, irq, cmi_en, cmi_inv, ext_sel, pll_t1, pll_e1;
   lics_pkg::lics_term_t rx_term, tx_term;
   logic [1:0] mps;
   int fail_count = 0;
   int cmp_count = 0;
   always #5 clk = ~clk;
   lics_host host (.clk(clk), .bus(bus), .rdata(rdata), .rvalid(rvalid));
   lics_regs uut (.clk(clk), .reset(reset), .bus(bus), .line(ln),
      .rdata(rdata), .rvalid(rvalid), .irq(irq),
      .line_code_inversion_enable(cmi_en), .line_code_invert(cmi_inv),
      .external_resistor_select(ext_sel), .rx_term(rx_term),
      .tx_term(tx_term), .master_clock_prescale(mps),
      .jitter_clock_select_0(js0), .jitter_clock_select_1(js1),
      .pll_t1_enable(pll_t1), .pll_e1_enable(pll_e1));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      bit ok;
      host.rd(a, d, ok);
      if (!ok) begin
         fail_count++;
         end_sim();
      end
      else chk(d, exp);
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk({5'h00, rx_term}, 8'(lics_pkg::LICS_TERM_EXT));
      chk({5'h00, tx_term}, 8'(lics_pkg::LICS_TERM_OFF));
      rd(lics_pkg::LICS_ADDR_STATUS, 8'h00);
      rd(lics_pkg::LICS_ADDR_MASK, 8'h00);
      rd(lics_pkg::LICS_ADDR_TERM, 8'h00);
      rd(8'h40, 8'h00);
   endtask
   task automatic t_code();
      host.wr(lics_pkg::LICS_ADDR_CODE, 8'hC0);
      wait_n(2);
      chk({6'h00, cmi_en, cmi_inv}, 8'h03);
      rd(lics_pkg::LICS_ADDR_CODE, 8'hC0);
      // The 133 ohm receive code is only legal with this resistor select.
      host.wr(lics_pkg::LICS_ADDR_CODE, 8'h20);
      wait_n(2);
      chk({5'h00, ext_sel, cmi_en, cmi_inv}, 8'h04);
   endtask
   task automatic t_term();
      // Expected codes follow the enum order of the termination type.
      logic [2:0] rxe [8] = '{0, 1, 2, 3, 4, 5, 0, 0};
      logic [2:0] txe [8] = '{6, 1, 2, 3, 4, 5, 6, 6};
      for (int i = 0; i < 8; i++) begin
         host.wr(lics_pkg::LICS_ADDR_TERM, {i[1:0], i[2:0], i[2:0]});
         wait_n(2);
         chk({5'h00, rx_term}, {5'h00, rxe[i]});
         chk({5'h00, tx_term}, {5'h00, txe[i]});
         chk({6'h00, mps}, {6'h00, i[1:0]});
      end
   endtask
   task automatic t_level();
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         ln.rx_level <= 4'(i);
         rd(lics_pkg::LICS_ADDR_INFO, {4'h0, 4'(i)});
      end
   endtask
   task automatic t_flags();
      host.wr(lics_pkg::LICS_ADDR_MASK, 8'h16);
      rd(lics_pkg::LICS_ADDR_MASK, lics_pkg::LICS_FLAG_MASK);
      @(posedge clk);
      ln.tx_open_circuit <= 1'b1;
      wait_n(3);
      chk({7'h00, irq}, 8'h01);
      rd(lics_pkg::LICS_ADDR_STATUS, 8'h02);
      chk({7'h00, irq}, 8'h00);
      @(posedge clk);
      ln.tx_open_circuit <= 1'b0;
      wait_n(3);
      chk({7'h00, irq}, 8'h01);
      @(posedge clk);
      ln.mode_6312k <= 1'b1;
      ln.tx_open_circuit <= 1'b1;
      ln.tx_current_limit <= 1'b1;
      rd(lics_pkg::LICS_ADDR_STATUS, 8'h00);
      @(posedge clk);
      ln.mode_6312k <= 1'b0;
      ln.mode_64k <= 1'b1;
      rd(lics_pkg::LICS_ADDR_STATUS, 8'h02);
      @(posedge clk);
      ln.mode_64k <= 1'b0;
      rd(lics_pkg::LICS_ADDR_STATUS, 8'h06);
      host.wr(lics_pkg::LICS_ADDR_CODE, 8'hA0);
      rd(lics_pkg::LICS_ADDR_STATUS, 8'h02);
      @(posedge clk);
      ln.tx_open_circuit <= 1'b0;
      ln.tx_current_limit <= 1'b0;
      // Clear the open-circuit edge first so the next request is the event's.
      rd(lics_pkg::LICS_ADDR_STATUS, 8'h00);
      @(posedge clk);
      ln.jitter_near_limit <= 1'b1;
      wait_n(3);
      chk({7'h00, irq}, 8'h01);
      rd(lics_pkg::LICS_ADDR_STATUS, 8'h10);
      rd(lics_pkg::LICS_ADDR_STATUS, 8'h00);
      host.wr(lics_pkg::LICS_ADDR_MASK, 8'h00);
      ln.jitter_near_limit <= 1'b0;
      wait_n(2);
      @(posedge clk);
      ln.jitter_near_limit <= 1'b1;
      wait_n(3);
      chk({7'h00, irq}, 8'h00);
      rd(lics_pkg::LICS_ADDR_STATUS, 8'h10);
   endtask
   task automatic t_pll();
      @(posedge clk);
      js0 <= 1'b1;
      wait_n(2);
      chk({6'h00, pll_e1, pll_t1}, 8'h01);
      @(posedge clk);
      js0 <= 1'b0;
      js1 <= 1'b1;
      wait_n(2);
      chk({6'h00, pll_e1, pll_t1}, 8'h02);
   endtask
   initial begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      wait_n(1);
      t_reset();
      t_code();
      t_term();
      t_level();
      t_flags();
      t_pll();
      end_sim();
   end
endmodule
`default_nettype wire
